// >>> logic/iqf_pkg.sv
package iqf_pkg;

    localparam logic [5:0] ADDR_CTRL_A   = 6'h18;
    localparam logic [5:0] ADDR_CTRL_B   = 6'h19;
    localparam logic [5:0] ADDR_DIVIDER  = 6'h1a;

    localparam logic [7:0] RST_CTRL_A    = 8'h12;
    localparam logic [7:0] RST_CTRL_B    = 8'h07;
    localparam logic [7:0] RST_DIVIDER   = 8'h01;

    localparam int         B_FOUR_WIRE   = 7;
    localparam int         B_WORD_WIDTH  = 3;
    localparam int         B_DRIVE_LSB   = 0;
    localparam int         DIV_BITS      = 4;

    localparam logic [6:0] PAYLOAD_BITS  = 7'h50;
    localparam logic [3:0] INLINE_GAP    = 4'h9;
    localparam logic [1:0] RST_CNT_MAX   = 2'h3;

    // Field order matches the control register, bit 7 first
    typedef struct packed {
        logic alternate_gain_bytes;
        logic append_gain_bytes;
        logic inline_framing;
        logic frame_marker_hiz;
        logic frame_marker_polarity;
        logic frame_marker_late;
        logic bit_clock_hiz;
        logic bit_clock_polarity;
    } iqf_ctrl_a_t;

    typedef struct packed {
        logic [79:0] bits;
        logic [6:0]  len;
    } iqf_frame_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_LEAD  = 3'b010,
        ST_SHIFT = 3'b100
    } iqf_state_t;

endpackage

// >>> logic/iqf_bit_clock_gen.sv
// Bit clock divider: one clock phase lasts div master clock cycles
`timescale 1ns/1ps
module iqf_bit_clock_gen
    import iqf_pkg::*;
(
    input  wire logic                mclk_i,
    input  wire logic                rst_n_i,
    input  wire logic                ce_i,
    input  wire logic [DIV_BITS-1:0] div_i,
    output logic                     level_o,
    output logic                     rise_o
);

    logic [DIV_BITS-1:0] cnt_reg;
    logic [DIV_BITS-1:0] cnt_next;
    logic                level_reg;
    logic                level_next;
    logic                rise_reg;
    logic                rise_next;
    logic [DIV_BITS-1:0] last;

    always_comb begin
        // A zero divisor would stop the link, so it runs as one
        last       = (div_i == '0) ? '0 : div_i - 4'h1;
        cnt_next   = cnt_reg;
        level_next = level_reg;
        rise_next  = 1'b0;
        if (ce_i) begin
            if (cnt_reg >= last) begin
                cnt_next   = '0;
                level_next = ~level_reg;
                rise_next  = ~level_reg;
            end else begin
                cnt_next = cnt_reg + 4'h1;
            end
        end else begin
            rise_next = rise_reg;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg   <= '0;
            level_reg <= 1'b0;
            rise_reg  <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            level_reg <= level_next;
            rise_reg  <= rise_next;
        end
    end

    assign level_o = level_reg;
    assign rise_o  = rise_reg;

    property p_rise_on_level_up;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && $rose(level_reg)) |-> rise_reg;
    endproperty
    a_rise_on_level_up: assert property (p_rise_on_level_up)
        else $error("rise pulse missing when bit clock goes high");

endmodule // iqf_bit_clock_gen

// >>> logic/iqf_serial_framer.sv
// Serial output framer: packs I, Q and gain bytes and shifts them out
`timescale 1ns/1ps
module iqf_serial_framer
    import iqf_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        reg_wr_i,
    input  wire logic [5:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        sample_strobe_i,
    input  wire logic [23:0] i_sample_i,
    input  wire logic [23:0] q_sample_i,
    input  wire logic [7:0]  atten_i,
    input  wire logic [5:0]  strength_i,
    input  wire logic        mod_reset_evt_i,
    input  wire logic        gain_loop_variant_i,
    input  wire logic        readback_active_i,
    input  wire logic        readback_bit_i,
    output logic             frame_marker_out_o,
    output logic             frame_marker_oe_o,
    output logic             serial_bit_clock_out_o,
    output logic             serial_bit_clock_oe_o,
    output logic             primary_serial_out_o,
    output logic             secondary_serial_out_o,
    output logic      [2:0]  output_drive_level_o
);

    // Builds the payload left aligned, MSB first
    function automatic iqf_frame_t build_frame(input logic [23:0] i_w, input logic [23:0] q_w,
                                               input logic wide, input logic [1:0] extra,
                                               input logic [15:0] gain_w, input logic inl);
        iqf_frame_t  f;
        logic [63:0] raw;
        logic [3:0]  nbytes;
        logic [7:0]  b;
        raw    = '0;
        nbytes = wide ? 4'h6 : 4'h4;
        if (wide)
            raw = {i_w, q_w, 16'h0000};
        else
            raw = {i_w[23:8], q_w[23:8], 32'h00000000};
        if (extra == 2'h2) begin
            raw[(wide ? 15 : 31) -: 16] = gain_w;
            nbytes = nbytes + 4'h2;
        end else if (extra == 2'h1) begin
            raw[(wide ? 15 : 31) -: 8] = gain_w[15:8];
            nbytes = nbytes + 4'h1;
        end
        f.bits = '1;
        if (inl) begin
            for (int k = 0; k < 8; k++) begin
                b = raw[63 - 8*k -: 8];
                f.bits[79 - 10*k -: 10] = {1'b0, b, 1'b1};
            end
            f.len = 7'({nbytes, 3'b000}) + 7'({3'b000, nbytes, 1'b0});
        end else begin
            f.bits[79 -: 64] = raw;
            f.len = 7'({nbytes, 3'b000});
        end
        return f;
    endfunction

    iqf_ctrl_a_t       ctrl_a_reg;
    iqf_ctrl_a_t       ctrl_a_next;
    logic [7:0]        ctrl_b_reg;
    logic [7:0]        ctrl_b_next;
    logic [7:0]        div_reg;
    logic [7:0]        div_next;
    logic [7:0]        rdata_reg;
    logic [7:0]        rdata_next;

    iqf_state_t        state_reg;
    iqf_state_t        state_next;
    iqf_frame_t        pend_reg;
    iqf_frame_t        pend_next;
    logic              pending_reg;
    logic              pending_next;
    logic [79:0]       shreg_reg;
    logic [79:0]       shreg_next;
    logic [6:0]        left_reg;
    logic [6:0]        left_next;
    logic [3:0]        gap_reg;
    logic [3:0]        gap_next;
    logic [1:0]        rst_cnt_reg;
    logic [1:0]        rst_cnt_next;
    logic              alt_sel_reg;
    logic              alt_sel_next;
    logic              data_reg;
    logic              data_next;
    logic              fs_reg;
    logic              fs_next;
    logic              fs_oe_reg;
    logic              fs_oe_next;
    logic              fs_pin_reg;
    logic              fs_pin_next;
    logic              ck_reg;
    logic              ck_oe_reg;
    logic              sec_reg;
    logic              sec_next;
    logic [2:0]        drive_reg;

    logic              bit_level;
    logic              bit_rise;
    logic              wide;
    logic              early;
    logic [1:0]        extra;
    logic [7:0]        atten_byte;
    logic [7:0]        status_byte;
    logic [15:0]       gain_word;
    logic [1:0]        rst_cnt_bump;

    iqf_bit_clock_gen u_bit_clock (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .div_i   (div_reg[DIV_BITS-1:0]),
        .level_o (bit_level),
        .rise_o  (bit_rise)
    );

    // Register file
    always_comb begin
        ctrl_a_next = ctrl_a_reg;
        ctrl_b_next = ctrl_b_reg;
        div_next    = div_reg;
        rdata_next  = rdata_reg;
        if (ce_i) begin
            if (reg_wr_i) begin
                case (reg_addr_i)
                    ADDR_CTRL_A:  ctrl_a_next = iqf_ctrl_a_t'(reg_wdata_i);
                    ADDR_CTRL_B:  ctrl_b_next = reg_wdata_i;
                    ADDR_DIVIDER: div_next    = {4'h0, reg_wdata_i[DIV_BITS-1:0]};
                    default:      ctrl_a_next = ctrl_a_reg;
                endcase
            end
            case (reg_addr_i)
                ADDR_CTRL_A:  rdata_next = 8'(ctrl_a_reg);
                ADDR_CTRL_B:  rdata_next = ctrl_b_reg;
                ADDR_DIVIDER: rdata_next = div_reg;
                default:      rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_a_reg <= iqf_ctrl_a_t'(RST_CTRL_A);
            ctrl_b_reg <= RST_CTRL_B;
            div_reg    <= RST_DIVIDER;
            rdata_reg  <= 8'h00;
        end else begin
            ctrl_a_reg <= ctrl_a_next;
            ctrl_b_reg <= ctrl_b_next;
            div_reg    <= div_next;
            rdata_reg  <= rdata_next;
        end
    end

    // Frame content
    always_comb begin
        wide         = ctrl_b_reg[B_WORD_WIDTH] & ~gain_loop_variant_i;
        early        = ~ctrl_a_reg.frame_marker_late | ctrl_a_reg.inline_framing;
        extra        = !ctrl_a_reg.append_gain_bytes ? 2'h0 :
                       (ctrl_a_reg.alternate_gain_bytes ? 2'h1 : 2'h2);
        atten_byte   = atten_i;
        status_byte  = {rst_cnt_reg, strength_i};
        if (extra == 2'h1)
            gain_word = alt_sel_reg ? {status_byte[7:1], 1'b1, 8'h00}
                                    : {atten_byte[7:1], 1'b0, 8'h00};
        else
            gain_word = {atten_byte, status_byte};
        rst_cnt_bump = (rst_cnt_reg == RST_CNT_MAX) ? RST_CNT_MAX : rst_cnt_reg + 2'h1;
    end

    // Capture and shift
    always_comb begin
        state_next   = state_reg;
        pend_next    = pend_reg;
        pending_next = pending_reg;
        shreg_next   = shreg_reg;
        left_next    = left_reg;
        gap_next     = gap_reg;
        rst_cnt_next = rst_cnt_reg;
        alt_sel_next = alt_sel_reg;
        data_next    = data_reg;
        fs_next      = fs_reg;
        if (ce_i) begin
            if (sample_strobe_i) begin
                pend_next    = build_frame(i_sample_i, q_sample_i, wide, extra, gain_word,
                                           ctrl_a_reg.inline_framing);
                pending_next = 1'b1;
                if (extra != 2'h0 && !(extra == 2'h1 && !alt_sel_reg))
                    rst_cnt_next = '0;
                if (extra == 2'h1)
                    alt_sel_next = ~alt_sel_reg;
            end
            // A reset event in the reporting cycle still counts
            if (mod_reset_evt_i)
                rst_cnt_next = (rst_cnt_next == '0) ? 2'h1 : rst_cnt_bump;
            if (bit_rise) begin
                case (state_reg)
                    ST_IDLE: begin
                        data_next = 1'b1;
                        fs_next   = 1'b0;
                        if (gap_reg != '0) begin
                            gap_next = gap_reg - 4'h1;
                        end else if (pending_reg) begin
                            pending_next = sample_strobe_i;
                            fs_next      = ~ctrl_a_reg.inline_framing;
                            if (early && !ctrl_a_reg.inline_framing) begin
                                state_next = ST_LEAD;
                                shreg_next = pend_reg.bits;
                                left_next  = pend_reg.len;
                            end else begin
                                state_next = ST_SHIFT;
                                data_next  = pend_reg.bits[79];
                                shreg_next = {pend_reg.bits[78:0], 1'b1};
                                left_next  = pend_reg.len - 7'h01;
                            end
                        end
                    end
                    ST_LEAD, ST_SHIFT: begin
                        fs_next = 1'b0;
                        if (left_reg == '0) begin
                            state_next = ST_IDLE;
                            data_next  = 1'b1;
                            gap_next   = ctrl_a_reg.inline_framing ? INLINE_GAP : '0;
                        end else begin
                            state_next = ST_SHIFT;
                            data_next  = shreg_reg[79];
                            shreg_next = {shreg_reg[78:0], 1'b1};
                            left_next  = left_reg - 7'h01;
                        end
                    end
                    default: state_next = ST_IDLE;
                endcase
            end
        end
    end

    always_comb begin
        fs_oe_next = ~ctrl_a_reg.inline_framing | ~ctrl_a_reg.frame_marker_hiz;
        // Inline framing holds the marker low whatever its polarity
        fs_pin_next = ctrl_a_reg.inline_framing ? 1'b0
                      : fs_next ^ ctrl_a_reg.frame_marker_polarity;
        sec_next   = ctrl_b_reg[B_FOUR_WIRE] & readback_active_i & readback_bit_i;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg   <= ST_IDLE;
            pend_reg    <= '0;
            pending_reg <= 1'b0;
            shreg_reg   <= '1;
            left_reg    <= '0;
            gap_reg     <= '0;
            rst_cnt_reg <= '0;
            alt_sel_reg <= 1'b0;
            data_reg    <= 1'b1;
            fs_reg      <= 1'b0;
            fs_oe_reg   <= 1'b0;
            fs_pin_reg  <= 1'b0;
            ck_reg      <= 1'b0;
            ck_oe_reg   <= 1'b0;
            sec_reg     <= 1'b0;
            drive_reg   <= RST_CTRL_B[B_DRIVE_LSB +: 3];
        end else if (ce_i) begin
            state_reg   <= state_next;
            pend_reg    <= pend_next;
            pending_reg <= pending_next;
            shreg_reg   <= shreg_next;
            left_reg    <= left_next;
            gap_reg     <= gap_next;
            rst_cnt_reg <= rst_cnt_next;
            alt_sel_reg <= alt_sel_next;
            data_reg    <= data_next;
            fs_reg      <= fs_next;
            fs_oe_reg   <= fs_oe_next;
            fs_pin_reg  <= fs_pin_next;
            ck_reg      <= bit_level ^ ctrl_a_reg.bit_clock_polarity;
            ck_oe_reg   <= ~ctrl_a_reg.bit_clock_hiz;
            sec_reg     <= sec_next;
            drive_reg   <= ctrl_b_reg[B_DRIVE_LSB +: 3];
        end
    end

    assign frame_marker_out_o     = fs_pin_reg;
    assign frame_marker_oe_o      = fs_oe_reg;
    assign serial_bit_clock_out_o = ck_reg;
    assign serial_bit_clock_oe_o  = ck_oe_reg;
    assign primary_serial_out_o   = data_reg;
    assign secondary_serial_out_o = sec_reg;
    assign output_drive_level_o   = drive_reg;
    assign reg_rdata_o            = rdata_reg;

    property p_idle_high;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (state_reg == ST_IDLE) |-> data_reg;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("data line not high while idle");

    property p_inline_marker;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && ctrl_a_reg.inline_framing) |=> (fs_oe_reg == !$past(ctrl_a_reg.frame_marker_hiz));
    endproperty
    a_inline_marker: assert property (p_inline_marker)
        else $error("marker enable wrong under inline framing");

    property p_clock_float;
        @(posedge mclk_i) disable iff (!rst_n_i)
        ce_i |=> (ck_oe_reg == !$past(ctrl_a_reg.bit_clock_hiz));
    endproperty
    a_clock_float: assert property (p_clock_float)
        else $error("bit clock enable does not follow its control");

    property p_lead_marker;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (state_reg == ST_LEAD) |-> (fs_reg && data_reg && !ctrl_a_reg.inline_framing);
    endproperty
    a_lead_marker: assert property (p_lead_marker)
        else $error("early marker slot wrong");

    property p_reset_saturate;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && mod_reset_evt_i && !sample_strobe_i) |=>
            (rst_cnt_reg == (($past(rst_cnt_reg) == 2'h3) ? 2'h3 : $past(rst_cnt_reg) + 2'h1));
    endproperty
    a_reset_saturate: assert property (p_reset_saturate)
        else $error("reset count not counting or not saturating");

    property p_plain_len;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && sample_strobe_i && !ctrl_a_reg.inline_framing && extra == 2'h2) |=>
            (pend_reg.len == ($past(wide) ? 7'd64 : 7'd48));
    endproperty
    a_plain_len: assert property (p_plain_len)
        else $error("plain frame length wrong");

    property p_inline_len;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && sample_strobe_i && ctrl_a_reg.inline_framing && extra == 2'h0) |=>
            (pend_reg.len + 7'd9 == ($past(wide) ? 7'd69 : 7'd49));
    endproperty
    a_inline_len: assert property (p_inline_len)
        else $error("inline frame length wrong");

    property p_alt_lsb;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && sample_strobe_i && !ctrl_a_reg.inline_framing && extra == 2'h1 && !wide) |=>
            (pend_reg.bits[40] == $past(alt_sel_reg));
    endproperty
    a_alt_lsb: assert property (p_alt_lsb)
        else $error("alternating byte marker bit wrong");

    property p_inline_gap;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && bit_rise && state_reg == ST_SHIFT && left_reg == '0 &&
         ctrl_a_reg.inline_framing) |=> (gap_reg == 4'h9 && data_reg);
    endproperty
    a_inline_gap: assert property (p_inline_gap)
        else $error("inline idle gap not started");

endmodule // iqf_serial_framer

// >>> tb/iqf_host_rx.sv
// Host serial receiver model: captures one frame after each arm pulse
`timescale 1ns/1ps
module iqf_host_rx (
    input  wire logic         mclk_i,
    input  wire logic         arm_i,
    input  wire logic         late_i,
    input  wire logic         inline_i,
    input  wire logic         mpol_i,
    input  wire logic         cpol_i,
    input  wire logic         bclk_i,
    input  wire logic         mark_i,
    input  wire logic         data_i,
    output logic      [111:0] frame_o,
    output logic      [7:0]   cnt_o
);
    logic bclk_q = 1'b0;
    logic go     = 1'b0;
    logic fall;
    logic start;

    // Sample mid-bit, on the falling phase, since data moves with the rising one
    assign fall  = bclk_q & ~(bclk_i ^ cpol_i);
    // Two-wire link: a low start bit opens the frame instead of the marker
    assign start = inline_i ? ~data_i : (mark_i ^ mpol_i);

    always @(posedge mclk_i) begin
        bclk_q <= bclk_i ^ cpol_i;
        if (arm_i) begin
            go      <= 1'b0;
            cnt_o   <= 8'h00;
            frame_o <= '1;
        end else if (fall && !go && start) begin
            go <= 1'b1;
            // Early marker rides on a lead bit that carries no payload
            if (inline_i || late_i) begin
                frame_o <= {frame_o[110:0], data_i};
                cnt_o   <= 8'h01;
            end
        end else if (fall && go && cnt_o != 8'h70) begin
            frame_o <= {frame_o[110:0], data_i};
            cnt_o   <= cnt_o + 8'h01;
        end
    end
endmodule // iqf_host_rx

// >>> tb/iqf_serial_framer_tb_top.sv
// Testbench for the serial output framer
`timescale 1ns/1ps
module iqf_serial_framer_tb_top;
    import iqf_pkg::*;
    logic         mclk, rst_n, wr, strobe, evt, glv, rb_act, rb_bit, arm;
    logic         late, inl, mpol, cpol, fs, fs_oe, bclk, bclk_oe, dout, dout2;
    logic [1:0]   rc;
    logic [2:0]   drv;
    logic [5:0]   addr, str;
    logic [7:0]   wdata, rdata, att;
    logic [23:0]  isamp, qsamp;
    logic [111:0] frame;
    logic [3:0]   md [8];
    int           fail_count = 0;
    int           compares = 0;

    iqf_serial_framer uut (
        .mclk_i(mclk), .rst_n_i(rst_n), .ce_i(1'b1), .reg_wr_i(wr), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .sample_strobe_i(strobe),
        .i_sample_i(isamp), .q_sample_i(qsamp), .atten_i(att), .strength_i(str),
        .mod_reset_evt_i(evt), .gain_loop_variant_i(glv), .readback_active_i(rb_act),
        .readback_bit_i(rb_bit), .frame_marker_out_o(fs), .frame_marker_oe_o(fs_oe),
        .serial_bit_clock_out_o(bclk), .serial_bit_clock_oe_o(bclk_oe),
        .primary_serial_out_o(dout), .secondary_serial_out_o(dout2),
        .output_drive_level_o(drv)
    );
    // Host inputs have pull-downs, so an undriven marker or clock reads low
    iqf_host_rx host (
        .mclk_i(mclk), .arm_i(arm), .late_i(late), .inline_i(inl), .mpol_i(mpol),
        .cpol_i(cpol), .bclk_i(bclk & bclk_oe), .mark_i(fs & fs_oe), .data_i(dout),
        .frame_o(frame), .cnt_o()
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic final_report();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string nm, input logic [111:0] e, input logic [111:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wreg(input logic [5:0] a, input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
    endtask

    task automatic rreg(input logic [5:0] a, input logic [7:0] e);
        @(negedge mclk);
        addr = a;
        repeat (2) @(negedge mclk);
        check("rdata", 112'(e), 112'(rdata));
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        rc = 2'h0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
    endtask

    task automatic ev(input int n);
        repeat (n) begin
            @(negedge mclk);
            evt = 1'b1;
            @(negedge mclk);
            evt = 1'b0;
        end
        rc = (int'(rc) + n > 3) ? 2'h3 : 2'(int'(rc) + n);
    endtask

    // m is {wide, append, alternate, inline}
    function automatic logic [111:0] expf(input logic [3:0] m, input bit sf,
                                          input logic [7:0] s);
        logic [47:0]  w;
        logic [7:0]   b [8];
        int           n;
        int           p;
        logic [111:0] r;
        r = '1;
        p = 111;
        w = m[3] ? {isamp, qsamp} : {isamp[23:8], qsamp[23:8], 16'h0};
        n = m[3] ? 6 : 4;
        for (int k = 0; k < 6; k++) b[k] = w[47-8*k -: 8];
        b[n] = m[1] ? (sf ? {s[7:1], 1'b1} : {att[7:1], 1'b0}) : att;
        b[n+1] = s;
        n = n + (m[2] ? (m[1] ? 1 : 2) : 0);
        for (int k = 0; k < n; k++)
            for (int j = 9; j >= 0; j--)
                if (m[0] || (j > 0 && j < 9)) begin
                    r[p] = (j == 9) ? 1'b0 : (j == 0) ? 1'b1 : b[k][j-1];
                    p--;
                end
        return r;
    endfunction

    // pl is {late, marker polarity, clock polarity}
    task automatic run(input logic [3:0] m, input logic [2:0] pl, input logic [3:0] dv,
                       input bit sf);
        logic [7:0] s;
        wreg(ADDR_CTRL_A, {m[1], m[2], m[0], 1'b1, pl[1], pl[2], 1'b0, pl[0]});
        wreg(ADDR_CTRL_B, {4'h0, m[3], 3'h7});
        wreg(ADDR_DIVIDER, {4'h0, dv});
        late = pl[2];
        mpol = pl[1];
        cpol = pl[0];
        inl = m[0];
        isamp = isamp + 24'h135795;
        qsamp = qsamp ^ 24'ha5c3f1;
        att = att - 8'h33;
        s = {rc, str};
        if (m[2] && (!m[1] || sf)) rc = 2'h0;
        @(negedge mclk);
        strobe = 1'b1;
        arm = 1'b1;
        @(negedge mclk);
        strobe = 1'b0;
        arm = 1'b0;
        // Next strobe only once the frame and its idle tail fit
        repeat (240 * int'(dv) + 40) @(negedge mclk);
        check("frame", expf({m[3] & ~glv, m[2:0]}, sf, s), frame);
        check("clock oe", 112'h1, 112'(bclk_oe));
        if (m[0]) check("marker oe", 112'h0, 112'(fs_oe));
        $display("test mode %b done", m);
    endtask

    initial begin
        rst_n = 1'b0;
        {wr, strobe, evt, glv, rb_act, rb_bit, arm, late, inl, mpol, cpol} = '0;
        addr = 6'h00;
        wdata = 8'h00;
        att = 8'hff;
        str = 6'h3c;
        isamp = 24'h812345;
        qsamp = 24'h7f00a5;
        md = '{4'b0000, 4'b1000, 4'b0100, 4'b1100, 4'b0001, 4'b0101, 4'b1001, 4'b1101};
        do_reset();
        rreg(ADDR_CTRL_A, 8'h12);
        rreg(ADDR_CTRL_B, 8'h07);
        rreg(ADDR_DIVIDER, 8'h01);
        rreg(6'h1b, 8'h00);
        check("idle", 112'h5, 112'({bclk_oe, dout, dout2, drv == 3'h7}));
        wreg(ADDR_DIVIDER, 8'hf3);
        rreg(ADDR_DIVIDER, 8'h03);
        wreg(6'h1c, 8'h55);
        rreg(ADDR_CTRL_A, 8'h12);
        rb_act = 1'b1;
        rb_bit = 1'b1;
        wreg(ADDR_CTRL_B, 8'h83);
        rreg(ADDR_CTRL_B, 8'h83);
        check("four wire", 112'h7, 112'({dout2, drv[1:0]}));
        $display("test registers done");
        for (int k = 0; k < 8; k++) begin
            ev(k);
            run(md[k], 3'b000, 4'h1, 1'b0);
        end
        run(4'b0000, 3'b111, 4'h2, 1'b0);
        run(4'b0101, 3'b100, 4'h1, 1'b0);
        wreg(ADDR_CTRL_A, 8'h20);
        repeat (2) @(negedge mclk);
        check("marker low", 112'h2, 112'({fs_oe, fs}));
        run(4'b1100, 3'b000, 4'h3, 1'b0);
        @(posedge bclk);
        begin
            realtime t0;
            t0 = $realtime;
            @(posedge bclk);
            check("bit period", 112'h30, 112'(int'($realtime - t0)));
        end
        glv = 1'b1;
        run(4'b1100, 3'b000, 4'h1, 1'b0);
        glv = 1'b0;
        do_reset();
        ev(2);
        run(4'b0110, 3'b000, 4'h1, 1'b0);
        run(4'b0110, 3'b000, 4'h1, 1'b1);
        ev(3);
        run(4'b0111, 3'b000, 4'h1, 1'b0);
        ev(4);
        run(4'b1111, 3'b000, 4'h1, 1'b1);
        final_report();
    end

    initial begin
        repeat (30000) @(posedge mclk);
        fail_count++;
        final_report();
    end
endmodule // iqf_serial_framer_tb_top
